// ===== verilog/fhr_core.sv
// Purpose: Fault history, fault snapshot, fault reset and parameter edit guard.
// Assumes: 50 MHz CLK; keypad and terminal pins are asynchronous.
// Notes:   Power cycling clears the fault through NRST.
// ==========================================================================
// How it works
// - Eight fault codes kept, newest first then seven older ones.
// - Snapshot of nine drive quantities captured at the newest fault.
// - Run hours at fault and hours between last two faults captured.
// - Command snapshot units digit: 0 stop, 1 run; upper digits zero.
// - Condition units digit holds control mode 0 to 5.
// - Condition tens digit holds motion state 0 to 4.
// - Condition hundreds digit: 0 motoring, 1 regenerating.
// - Condition thousands digit holds suppression 0 to 3.
// - Stop/reset key during a fault clears it; power cycle also clears.
// - Terminal reset input clears the fault when terminals command the drive.
// - Bus fault-reset command clears the fault when bus commands the drive.
// - Auto restart after supply dip only when restart enable is set.
// - Locked parameters reject edits until matching password entered.
// - Edited value commits only on OK key press.
// - Run-locked parameters refuse changes while the drive runs.
`timescale 1ns/1ns
`include "fhr_map.svh"

module fhr_core (
   input  wire logic                CLK,
   input  wire logic                NRST,
   input  wire logic                WB_CYC_I,
   input  wire logic                WB_STB_I,
   input  wire logic                WB_WE_I,
   input  wire logic [7:0]          WB_ADR_I,
   input  wire logic [3:0]          WB_SEL_I,
   input  wire logic [31:0]         WB_DAT_I,
   output logic      [31:0]         WB_DAT_O,
   output logic                     WB_ACK_O,
   output logic                     IRQ,
   input  wire logic                FAULT_EVENT,
   input  wire logic [7:0]          FAULT_CODE,
   input  wire logic [15:0]         OUT_CURRENT,
   input  wire logic [15:0]         OUT_VOLTAGE,
   input  wire logic [15:0]         MOTOR_SPEED,
   input  wire logic [15:0]         DC_BUS_VOLTAGE,
   input  wire logic [15:0]         OUT_TORQUE,
   input  wire logic [15:0]         TARGET_FREQ,
   input  wire logic [15:0]         OPER_FREQ,
   input  wire logic [15:0]         SYNC_FREQ,
   input  wire logic [15:0]         PEAK_TEMP,
   input  wire logic [15:0]         RUN_HOURS,
   input  wire logic                RUN_CMD,
   input  wire fhr_pkg::fhr_mode_type   CTRL_MODE,
   input  wire fhr_pkg::fhr_motion_type MOTION_STATE,
   input  wire logic                REGEN,
   input  wire fhr_pkg::fhr_supp_type   SUPPRESS,
   input  wire logic                CMD_FROM_TERMINAL,
   input  wire logic                CMD_FROM_BUS,
   input  wire logic                SUPPLY_DIP_END,
   input  wire logic                DRIVE_RUNNING,
   input  wire logic                STOP_KEY,
   input  wire logic                TERM_RESET_IN,
   input  wire logic                TERM_RUN_IN,
   input  wire logic                OK_KEY,
   input  wire logic                PARAM_RUN_LOCKED,
   output logic                     FAULT_ACTIVE,
   output logic                     AUTO_RESTART,
   output logic      [15:0]         PARAM_VALUE
);
   import fhr_pkg::*;

   fhr_state_type s_reg;
   fhr_state_type s_next;

   // =======================================================================
   // Helpers
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
      hit = (adr == off);
   endfunction : hit

   function automatic logic [3:0] w1c(input logic [3:0] cur, input logic [3:0] clr,
                                      input logic [3:0] set);
      w1c = (cur & ~clr) | set;
   endfunction : w1c

   logic        wb_req;
   logic        wb_wr;
   logic        stop_rise;
   logic        term_rise;
   logic        ok_rise;
   logic        edit_ok;
   logic        clr_key;
   logic        clr_term;
   logic        clr_bus;
   logic        fault_clear;
   logic [2:0]  irq_set;
   logic [31:0] rd;
   logic [3:0]  stat_w;

   always_comb begin
      s_next      = s_reg;
      // Writes land at the edge where the master sees ack high
      wb_req      = WB_CYC_I && WB_STB_I && (s_reg.bus == FHR_BUS_ACK);
      wb_wr       = wb_req && WB_WE_I && WB_SEL_I[0];
      stop_rise   = s_reg.stop_key_s[1] && !s_reg.stop_key_d;
      term_rise   = s_reg.term_rst_s[1] && !s_reg.term_rst_d;
      ok_rise     = s_reg.ok_key_s[1] && !s_reg.ok_key_d;
      // Keypad stop during a displayed fault
      clr_key     = stop_rise && s_reg.fault;
      // Terminal reset counts only once the run terminal is released
      clr_term    = term_rise && CMD_FROM_TERMINAL && s_reg.control[`FHR_CTRL_TERMRST_BIT]
                    && !s_reg.term_run_s[1];
      clr_bus     = wb_wr && hit(WB_ADR_I, `FHR_OFF_CONTROL)
                    && WB_DAT_I[`FHR_CTRL_BUSRST_BIT] && CMD_FROM_BUS;
      fault_clear = s_reg.fault && (clr_key || clr_term || clr_bus);
      // Locked unless the entered password matches
      edit_ok     = (!s_reg.control[`FHR_CTRL_LOCK_BIT]
                     || (s_reg.entered == s_reg.lock_pwd))
                    && !(PARAM_RUN_LOCKED && DRIVE_RUNNING);
      irq_set     = 3'h0;
      rd          = 32'h0000_0000;
      stat_w      = 4'h0;

      // Synchronisers, first stage feeds only the second
      s_next.stop_key_s = {s_reg.stop_key_s[0], STOP_KEY};
      s_next.term_rst_s = {s_reg.term_rst_s[0], TERM_RESET_IN};
      s_next.term_run_s = {s_reg.term_run_s[0], TERM_RUN_IN};
      s_next.ok_key_s   = {s_reg.ok_key_s[0], OK_KEY};
      s_next.stop_key_d = s_reg.stop_key_s[1];
      s_next.term_rst_d = s_reg.term_rst_s[1];
      s_next.ok_key_d   = s_reg.ok_key_s[1];

      // ====================================================================
      // Fault capture
      if (fault_clear) begin
         s_next.fault = 1'b0;
         irq_set[`FHR_IRQ_CLEAR_BIT] = 1'b1;
      end
      if (FAULT_EVENT) begin
         s_next.fault = 1'b1;
         irq_set[`FHR_IRQ_FAULT_BIT] = 1'b1;
         for (int i = `FHR_HIST_DEPTH - 1; i > 0; i--) begin
            s_next.hist[i] = s_reg.hist[i-1];
         end
         s_next.hist[0]   = FAULT_CODE;
         s_next.snap[0]   = OUT_CURRENT;
         s_next.snap[1]   = OUT_VOLTAGE;
         s_next.snap[2]   = MOTOR_SPEED;
         s_next.snap[3]   = DC_BUS_VOLTAGE;
         s_next.snap[4]   = OUT_TORQUE;
         s_next.snap[5]   = TARGET_FREQ;
         s_next.snap[6]   = OPER_FREQ;
         s_next.snap[7]   = SYNC_FREQ;
         s_next.snap[8]   = PEAK_TEMP;
         s_next.run_hours = RUN_HOURS;
         s_next.gap_hours = 16'(RUN_HOURS - s_reg.last_hours);
         s_next.last_hours = RUN_HOURS;
         s_next.cmd_snap  = {12'h000, 3'h0, RUN_CMD};
         s_next.cond_snap = {SUPPRESS,
                             {3'h0, REGEN},
                             MOTION_STATE,
                             CTRL_MODE};
      end

      // Restart after supply dip only when enabled
      s_next.restart = SUPPLY_DIP_END && s_reg.control[`FHR_CTRL_RESTART_BIT]
                       && !s_reg.fault;

      // ====================================================================
      // Parameter edit: commit on OK only
      if (ok_rise) begin
         if (edit_ok) begin
            s_next.param = s_reg.pending;
         end else begin
            irq_set[`FHR_IRQ_REJECT_BIT] = 1'b1;
         end
      end

      // ====================================================================
      // Wishbone slave, one wait state then ack
      if (hit(WB_ADR_I, `FHR_OFF_STATUS)) begin
         rd = {30'h0, s_reg.restart, s_reg.fault};
      end else if (hit(WB_ADR_I, `FHR_OFF_CONTROL)) begin
         rd = {28'h0, s_reg.control & 4'hB};
      end else if (hit(WB_ADR_I, `FHR_OFF_IRQ_STATUS)) begin
         rd = {29'h0, s_reg.irq_status};
      end else if (hit(WB_ADR_I, `FHR_OFF_IRQ_MASK)) begin
         rd = {29'h0, s_reg.irq_mask};
      end else if (hit(WB_ADR_I, `FHR_OFF_EDIT)) begin
         rd = {16'h0, s_reg.pending};
      end else if (hit(WB_ADR_I, `FHR_OFF_PARAM_VALUE)) begin
         rd = {16'h0, s_reg.param};
      end else if (hit(WB_ADR_I, `FHR_OFF_CMD_SNAP)) begin
         rd = {16'h0, s_reg.cmd_snap};
      end else if (hit(WB_ADR_I, `FHR_OFF_COND_SNAP)) begin
         rd = {16'h0, s_reg.cond_snap};
      end else if (hit(WB_ADR_I, `FHR_OFF_RUN_HOURS)) begin
         rd = {16'h0, s_reg.run_hours};
      end else if (hit(WB_ADR_I, `FHR_OFF_GAP_HOURS)) begin
         rd = {16'h0, s_reg.gap_hours};
      end else begin
         for (int j = 0; j < `FHR_SNAP_WORDS; j++) begin
            if (WB_ADR_I == 8'(`FHR_OFF_SNAP_BASE + 4 * j)) begin
               rd = {16'h0, s_reg.snap[j]};
            end
         end
         for (int k = 0; k < `FHR_HIST_DEPTH; k++) begin
            if (WB_ADR_I == 8'(`FHR_OFF_HIST_BASE + 4 * k)) begin
               rd = {24'h0, s_reg.hist[k]};
            end
         end
      end

      unique case (s_reg.bus)
         FHR_BUS_IDLE: begin
            if (WB_CYC_I && WB_STB_I) begin
               s_next.bus = FHR_BUS_ACK;
               s_next.dat = WB_WE_I ? 32'h0000_0000 : rd;
            end
         end
         FHR_BUS_ACK: begin
            s_next.bus = FHR_BUS_IDLE;
            s_next.dat = 32'h0000_0000;
         end
      endcase

      if (wb_wr) begin
         if (hit(WB_ADR_I, `FHR_OFF_CONTROL)) begin
            s_next.control = WB_DAT_I[3:0] & 4'hB;
         end
         if (hit(WB_ADR_I, `FHR_OFF_IRQ_MASK)) begin
            s_next.irq_mask = WB_DAT_I[2:0];
         end
         if (hit(WB_ADR_I, `FHR_OFF_IRQ_STATUS)) begin
            stat_w = {1'b0, WB_DAT_I[2:0]};
         end
      end
      if (wb_req && WB_WE_I && (WB_SEL_I[1:0] == 2'h3)) begin
         if (hit(WB_ADR_I, `FHR_OFF_PASSWORD)) begin
            s_next.entered = WB_DAT_I[15:0];
         end
         if (hit(WB_ADR_I, `FHR_OFF_LOCK_PWD) && edit_ok) begin
            s_next.lock_pwd = WB_DAT_I[15:0];
         end
         if (hit(WB_ADR_I, `FHR_OFF_EDIT)) begin
            s_next.pending = WB_DAT_I[15:0];
         end
      end

      // Set beats clear in the same cycle
      s_next.irq_status = 3'(w1c({1'b0, s_reg.irq_status}, stat_w, {1'b0, irq_set}));
      s_next.irq        = |(s_next.irq_status & s_next.irq_mask);
   end

   // =======================================================================
   // State register
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s_reg.bus        <= FHR_BUS_IDLE;
         s_reg.dat        <= 32'h0000_0000;
         s_reg.hist       <= '0;
         s_reg.snap       <= '0;
         s_reg.cmd_snap   <= 16'h0000;
         s_reg.cond_snap  <= 16'h0000;
         s_reg.run_hours  <= 16'h0000;
         s_reg.gap_hours  <= 16'h0000;
         s_reg.last_hours <= 16'h0000;
         s_reg.fault      <= 1'b0;
         s_reg.restart    <= 1'b0;
         s_reg.control    <= `FHR_CONTROL_RESET;
         s_reg.irq_status <= 3'h0;
         s_reg.irq_mask   <= 3'h0;
         s_reg.irq        <= 1'b0;
         s_reg.lock_pwd   <= `FHR_PASSWORD_RESET;
         s_reg.entered    <= `FHR_PASSWORD_RESET;
         s_reg.param      <= `FHR_PARAM_RESET;
         s_reg.pending    <= `FHR_PARAM_RESET;
         s_reg.stop_key_s <= 2'h0;
         s_reg.term_rst_s <= 2'h0;
         s_reg.term_run_s <= 2'h0;
         s_reg.ok_key_s   <= 2'h0;
         s_reg.stop_key_d <= 1'b0;
         s_reg.term_rst_d <= 1'b0;
         s_reg.ok_key_d   <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // =======================================================================
   // Outputs straight from flops
   assign WB_DAT_O     = s_reg.dat;
   assign WB_ACK_O     = (s_reg.bus == FHR_BUS_ACK);
   assign IRQ          = s_reg.irq;
   assign FAULT_ACTIVE = s_reg.fault;
   assign AUTO_RESTART = s_reg.restart;
   assign PARAM_VALUE  = s_reg.param;

endmodule : fhr_core

// ===== common/fhr_map.svh
// Purpose: Constants for the fault history and reset block.
// Assumes: Classic Wishbone, 32-bit data, byte addresses.
// Notes:   Offsets are word aligned.
`ifndef FHR_MAP_SVH
`define FHR_MAP_SVH

// ==========================================================================
// Register offsets
`define FHR_OFF_STATUS       8'h00
`define FHR_OFF_CONTROL      8'h04
`define FHR_OFF_IRQ_STATUS   8'h08
`define FHR_OFF_IRQ_MASK     8'h0C
`define FHR_OFF_PASSWORD     8'h10
`define FHR_OFF_LOCK_PWD     8'h14
`define FHR_OFF_EDIT         8'h18
`define FHR_OFF_PARAM_VALUE  8'h1C
`define FHR_OFF_CMD_SNAP     8'h20
`define FHR_OFF_COND_SNAP    8'h24
`define FHR_OFF_RUN_HOURS    8'h28
`define FHR_OFF_GAP_HOURS    8'h2C
`define FHR_OFF_SNAP_BASE    8'h40
`define FHR_OFF_HIST_BASE    8'h80

// ==========================================================================
// Field positions and sizes
`define FHR_HIST_DEPTH       8
`define FHR_SNAP_WORDS       9
`define FHR_CODE_W           8
`define FHR_CTRL_RESTART_BIT 0
`define FHR_CTRL_LOCK_BIT    1
`define FHR_CTRL_BUSRST_BIT  2
`define FHR_CTRL_TERMRST_BIT 3
`define FHR_IRQ_FAULT_BIT    0
`define FHR_IRQ_CLEAR_BIT    1
`define FHR_IRQ_REJECT_BIT   2
`define FHR_IRQ_W            3
`define FHR_CONTROL_RESET    4'h0
`define FHR_PASSWORD_RESET   16'h0000
`define FHR_PARAM_RESET      16'h0000

`endif

// ===== common/fhr_pkg.sv
// Purpose: Types for the fault history and reset block.
// Assumes: Constants live in fhr_map.svh.
// Notes:   Digit fields are 4-bit decimal digits.
package fhr_pkg;

   // =======================================================================
   // Snapshot encodings, bus states and state record
   typedef enum logic [3:0] {
      FHR_MODE_VPH   = 4'h0,
      FHR_MODE_OLVS  = 4'h1,
      FHR_MODE_CLVS  = 4'h2,
      FHR_MODE_OLTQ  = 4'h3,
      FHR_MODE_CLTQ  = 4'h4,
      FHR_MODE_SEPVF = 4'h5
   } fhr_mode_type;

   typedef enum logic [3:0] {
      FHR_MOT_SHUT  = 4'h0,
      FHR_MOT_ACCEL = 4'h1,
      FHR_MOT_DECEL = 4'h2,
      FHR_MOT_REDUC = 4'h3,
      FHR_MOT_STEADY = 4'h4
   } fhr_motion_type;

   typedef enum logic [3:0] {
      FHR_SUP_NONE = 4'h0,
      FHR_SUP_OC   = 4'h1,
      FHR_SUP_OV   = 4'h2,
      FHR_SUP_UV   = 4'h3
   } fhr_supp_type;

   typedef enum {
      FHR_BUS_IDLE,
      FHR_BUS_ACK
   } fhr_bus_type;

   typedef struct packed {
      fhr_bus_type  bus;
      logic [31:0]  dat;
      logic [0:7][7:0]  hist;
      logic [0:8][15:0] snap;
      logic [15:0]  cmd_snap;
      logic [15:0]  cond_snap;
      logic [15:0]  run_hours;
      logic [15:0]  gap_hours;
      logic [15:0]  last_hours;
      logic         fault;
      logic         restart;
      logic [3:0]   control;
      logic [2:0]   irq_status;
      logic [2:0]   irq_mask;
      logic         irq;
      logic [15:0]  lock_pwd;
      logic [15:0]  entered;
      logic [15:0]  param;
      logic [15:0]  pending;
      logic [1:0]   stop_key_s;
      logic [1:0]   term_rst_s;
      logic [1:0]   term_run_s;
      logic [1:0]   ok_key_s;
      logic         stop_key_d;
      logic         term_rst_d;
      logic         ok_key_d;
   } fhr_state_type;

endpackage : fhr_pkg

// ===== verif/fhr_core_props.sv
// Purpose: Port-level temporal checks of fhr_core.
// Assumes: One clock, NRST async active low.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ns
module fhr_core_props (
   input wire logic        CLK,
   input wire logic        NRST,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic        WB_ACK_O,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        FAULT_EVENT,
   input wire logic        FAULT_ACTIVE,
   input wire logic        SUPPLY_DIP_END,
   input wire logic        AUTO_RESTART,
   input wire logic        STOP_KEY,
   input wire logic        TERM_RESET_IN,
   input wire logic        OK_KEY,
   input wire logic        DRIVE_RUNNING,
   input wire logic        PARAM_RUN_LOCKED,
   input wire logic [15:0] PARAM_VALUE
);
   // ==========================================================
   // Helper: cycles since OK was seen, saturating
   logic [3:0] ok_age_reg;
   logic [3:0] ok_age_next;
   always_comb ok_age_next = OK_KEY ? 4'h0 : ok_age_reg + {3'h0, ok_age_reg != 4'hF};
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) ok_age_reg <= 4'hF;
      else ok_age_reg <= ok_age_next;
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_ack_resp; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
   property p_dat_zero; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
   a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
   property p_fault_set; FAULT_EVENT |=> FAULT_ACTIVE; endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault not latched");
   sequence s_quiet; FAULT_ACTIVE && !STOP_KEY && !TERM_RESET_IN && !WB_WE_I; endsequence
   property p_fault_hold; s_quiet [*5] |=> FAULT_ACTIVE; endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault lost");
   property p_stop_clear; $rose(STOP_KEY) && FAULT_ACTIVE |-> ##[1:5] !FAULT_ACTIVE; endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("stop key no clear");
   property p_restart_src; !SUPPLY_DIP_END |=> !AUTO_RESTART; endproperty
   a_restart_src: assert property (p_restart_src) else $error("restart no dip");
   property p_restart_flt; FAULT_ACTIVE |=> !AUTO_RESTART; endproperty
   a_restart_flt: assert property (p_restart_flt) else $error("restart in fault");
   property p_ok_commit; $changed(PARAM_VALUE) |-> ok_age_reg <= 4'h6; endproperty
   a_ok_commit: assert property (p_ok_commit) else $error("commit without OK");
   property p_run_lock; (DRIVE_RUNNING && PARAM_RUN_LOCKED) [*2] |-> $stable(PARAM_VALUE); endproperty
   a_run_lock: assert property (p_run_lock) else $error("edit while running");
   c_fault: cover property (FAULT_EVENT ##1 FAULT_ACTIVE);
   c_stop: cover property ($rose(STOP_KEY) && FAULT_ACTIVE);
   c_commit: cover property ($changed(PARAM_VALUE));
endmodule : fhr_core_props

// ===== verif/fhr_panel_model.sv
// Purpose: Keypad and input terminal model.
// Assumes: Drives pins right after a rising edge.
// Notes:   Cool-down wait is scaled down to keep runs short.
`timescale 1ns/1ns
module fhr_panel_model #(
   parameter int COOL_CYC = 8
) (
   input  wire logic CLK,
   output logic      STOP_KEY,
   output logic      TERM_RESET_IN,
   output logic      TERM_RUN_IN,
   output logic      OK_KEY
);
   initial {STOP_KEY, TERM_RESET_IN, TERM_RUN_IN, OK_KEY} = 4'h0;
   task automatic hold(input int n);
      repeat (n) @(posedge CLK);
   endtask : hold
   // Held long enough to pass the pin synchronisers
   task automatic press_stop();
      hold(COOL_CYC);
      STOP_KEY <= 1'b1;
      hold(6);
      STOP_KEY <= 1'b0;
      hold(6);
   endtask : press_stop
   task automatic press_ok();
      OK_KEY <= 1'b1;
      hold(8);
      OK_KEY <= 1'b0;
      hold(6);
   endtask : press_ok
   task automatic run_on();
      TERM_RUN_IN <= 1'b1;
      hold(2);
   endtask : run_on
   task automatic term_reset();
      TERM_RUN_IN <= 1'b0;
      hold(COOL_CYC);
      TERM_RESET_IN <= 1'b1;
      hold(6);
      TERM_RESET_IN <= 1'b0;
      hold(6);
   endtask : term_reset
endmodule : fhr_panel_model

// ===== verif/fhr_core_tb_top.sv
// Purpose: Self-checking bench for fhr_core.
// Assumes: Wishbone acks one cycle after the request.
// Notes:   NRST also stands in for a power cycle.
`timescale 1ns/1ns
`include "fhr_map.svh"
module fhr_core_tb_top;
   import fhr_pkg::*;
   logic CLK, NRST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, IRQ, FAULT_EVENT, RUN_CMD, REGEN;
   logic CMD_FROM_TERMINAL, CMD_FROM_BUS, SUPPLY_DIP_END, DRIVE_RUNNING, PARAM_RUN_LOCKED;
   logic FAULT_ACTIVE, AUTO_RESTART, STOP_KEY, TERM_RESET_IN, TERM_RUN_IN, OK_KEY;
   logic [7:0]     WB_ADR_I, FAULT_CODE;
   logic [3:0]     WB_SEL_I;
   logic [31:0]    WB_DAT_I, WB_DAT_O, rd;
   logic [15:0]    snap_in [0:8];
   logic [15:0]    RUN_HOURS, PARAM_VALUE;
   fhr_mode_type   CTRL_MODE;
   fhr_motion_type MOTION_STATE;
   fhr_supp_type   SUPPRESS;
   int             error_cnt, check_count;
   fhr_core fhr_core_inst (.OUT_CURRENT(snap_in[0]), .OUT_VOLTAGE(snap_in[1]),
      .MOTOR_SPEED(snap_in[2]), .DC_BUS_VOLTAGE(snap_in[3]), .OUT_TORQUE(snap_in[4]),
      .TARGET_FREQ(snap_in[5]), .OPER_FREQ(snap_in[6]), .SYNC_FREQ(snap_in[7]),
      .PEAK_TEMP(snap_in[8]), .*);
   fhr_panel_model fhr_panel_model_inst (.*);
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   // ==========================================================
   // Bus and compare tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
   endtask : cyc
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, we, a, d};
      do begin
         @(posedge CLK);
         n++;
      end while (WB_ACK_O !== 1'b1 && n < 40);
      if (n >= 40) chk(32'h1, 32'h0);
      rd = WB_DAT_O;
      {WB_CYC_I, WB_STB_I, WB_WE_I} <= 3'b000;
      @(posedge CLK);
   endtask : wb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk
   task automatic fault(input int i);
      {FAULT_EVENT, FAULT_CODE, RUN_CMD, REGEN} <= {1'b1, 8'(8'h10 + i), i[0], i[1]};
      CTRL_MODE <= fhr_mode_type'(4'(i % 6));
      MOTION_STATE <= fhr_motion_type'(4'(i % 5));
      SUPPRESS <= fhr_supp_type'(4'(i % 4));
      RUN_HOURS <= 16'(100 + 10 * i);
      for (int k = 0; k < 9; k++) snap_in[k] <= 16'(i * 16 + k);
      @(posedge CLK);
      FAULT_EVENT <= 1'b0;
      cyc(1);
   endtask : fault
   task automatic stop_test();
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   initial begin
      cyc(5000);
      chk(32'h1, 32'h0);
      stop_test();
   end
   // ==========================================================
   // Test sequence
   initial begin
      {NRST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, WB_SEL_I} = {44'h0, 4'hF};
      {FAULT_EVENT, FAULT_CODE, RUN_CMD, REGEN, RUN_HOURS} = '0;
      {CMD_FROM_TERMINAL, CMD_FROM_BUS, SUPPLY_DIP_END, DRIVE_RUNNING, PARAM_RUN_LOCKED} = '0;
      {CTRL_MODE, MOTION_STATE, SUPPRESS} = {FHR_MODE_VPH, FHR_MOT_SHUT, FHR_SUP_NONE};
      for (int k = 0; k < 9; k++) snap_in[k] = 16'h0;
      cyc(6);
      NRST <= 1'b1;
      rdchk(`FHR_OFF_STATUS, 32'h0);
      wb(1'b1, 8'h3C, 32'hFFFF);
      rdchk(8'h3C, 32'h0);
      for (int i = 0; i < 9; i++) begin
         fault(i);
         chk(FAULT_ACTIVE, 32'h1);
         rdchk(`FHR_OFF_CMD_SNAP, {31'h0, i[0]});
         rdchk(`FHR_OFF_COND_SNAP, {16'h0, 4'(i % 4), 3'h0, i[1], 4'(i % 5), 4'(i % 6)});
         rdchk(`FHR_OFF_RUN_HOURS, 32'(100 + 10 * i));
         rdchk(`FHR_OFF_GAP_HOURS, (i == 0) ? 32'h64 : 32'hA);
      end
      for (int j = 0; j < 8; j++) rdchk(8'(8'h80 + 4 * j), 32'(24 - j));
      for (int k = 0; k < 9; k++) rdchk(8'(8'h40 + 4 * k), 32'(128 + k));
      chk(IRQ, 32'h0);
      wb(1'b1, `FHR_OFF_IRQ_MASK, 32'h1);
      cyc(2);
      chk(IRQ, 32'h1);
      wb(1'b1, `FHR_OFF_IRQ_STATUS, 32'h1);
      cyc(2);
      chk(IRQ, 32'h0);
      fhr_panel_model_inst.press_stop();
      chk(FAULT_ACTIVE, 32'h0);
      rdchk(`FHR_OFF_IRQ_STATUS, 32'h2);
      fault(1);
      wb(1'b1, `FHR_OFF_CONTROL, 32'h8);
      fhr_panel_model_inst.run_on();
      fhr_panel_model_inst.term_reset();
      chk(FAULT_ACTIVE, 32'h1);
      CMD_FROM_TERMINAL <= 1'b1;
      fhr_panel_model_inst.run_on();
      fhr_panel_model_inst.term_reset();
      chk(FAULT_ACTIVE, 32'h0);
      fault(2);
      CMD_FROM_BUS <= 1'b1;
      wb(1'b1, `FHR_OFF_CONTROL, 32'hC);
      chk(FAULT_ACTIVE, 32'h0);
      rdchk(`FHR_OFF_CONTROL, 32'h8);
      SUPPLY_DIP_END <= 1'b1;
      cyc(3);
      chk(AUTO_RESTART, 32'h0);
      wb(1'b1, `FHR_OFF_CONTROL, 32'h9);
      cyc(2);
      chk(AUTO_RESTART, 32'h1);
      fault(3);
      cyc(1);
      chk(AUTO_RESTART, 32'h0);
      NRST <= 1'b0;
      cyc(2);
      chk(FAULT_ACTIVE, 32'h0);
      NRST <= 1'b1;
      wb(1'b1, `FHR_OFF_EDIT, 32'h1234);
      cyc(8);
      chk(PARAM_VALUE, 32'h0);
      fhr_panel_model_inst.press_ok();
      chk(PARAM_VALUE, 32'h1234);
      wb(1'b1, `FHR_OFF_LOCK_PWD, 32'hBEEF);
      wb(1'b1, `FHR_OFF_CONTROL, 32'h2);
      wb(1'b1, `FHR_OFF_EDIT, 32'h5678);
      fhr_panel_model_inst.press_ok();
      chk(PARAM_VALUE, 32'h1234);
      rdchk(`FHR_OFF_IRQ_STATUS, 32'h4);
      wb(1'b1, `FHR_OFF_PASSWORD, 32'hBEEF);
      fhr_panel_model_inst.press_ok();
      chk(PARAM_VALUE, 32'h5678);
      {DRIVE_RUNNING, PARAM_RUN_LOCKED} <= 2'b11;
      wb(1'b1, `FHR_OFF_EDIT, 32'h9ABC);
      fhr_panel_model_inst.press_ok();
      chk(PARAM_VALUE, 32'h5678);
      DRIVE_RUNNING <= 1'b0;
      fhr_panel_model_inst.press_ok();
      chk(PARAM_VALUE, 32'h9ABC);
      stop_test();
   end
endmodule : fhr_core_tb_top
bind fhr_core fhr_core_props fhr_core_props_inst (.*);
